// *** rtl/modbus_write_multi_and_diagnostics.sv ***
// Slave frame interpreter for multi-register write and diagnostics
//
// Overview of operation
// [R1] Write request: addr, fc, start, count, len, data, crc
// [R2] Register indices are zero based
// [R3] Write reply: addr, fc, start, count, new crc
// [R4] Payload words high byte first, ascending index
// [R5] Diag request: addr, fc, subfunction, data, crc
// [R6] Subfunction zero echoes the request unchanged
// [R7] Subfunction one: echo first, then restart port
// [R8] Restart ends within one second, then accept
// [R9] Subfunction two returns diagnostic status word
// [R10] Subfunction ten clears counters and status, echoes
// [R11] Persisting conditions may set again after clear
// [R12] Count checksum errors; subfunction twelve returns count
// [R13] Checksum error counter is 16 bits, wraps
// [R14] Bad checksum frame only bumps error counter
`timescale 1ns/1ns
module modbus_write_multi_and_diagnostics
  import modbus_diag_pkg::*;
#(
  parameter int FRAME_DEPTH    = 256,
  parameter int RESTART_CYCLES_P = RESTART_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] slave_addr,
  input  wire rx_byte_t   rx,
  input  wire logic       rx_frame_end,
  output logic      [7:0] tx_data,
  output logic            tx_valid,
  input  wire logic       tx_ready,
  output reg_write_t      reg_write,
  input  wire logic [15:0] diag_event,
  output diag_status_t    diagnostic_status_word,
  output logic     [15:0] crc_error_count,
  output logic            port_restart
);
  localparam int RCW = $clog2(RESTART_CYCLES_P + 1);
  localparam logic [RCW-1:0] RESTART_LAST = RCW'(RESTART_CYCLES_P - 1);
  localparam logic [8:0] FRAME_FULL = 9'(FRAME_DEPTH);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t         state,     next_state;
  logic [8:0]     rx_cnt,    next_rx_cnt;
  logic [15:0]    rx_crc,    next_rx_crc;
  logic           overflow,  next_overflow;
  logic [7:0]     wr_idx,    next_wr_idx;
  logic [2:0]     tx_idx,    next_tx_idx;
  logic [15:0]    tx_crc,    next_tx_crc;
  logic [7:0]     next_tx_data;
  reg_write_t     next_reg_write;
  diag_status_t   next_status;
  logic [15:0]    next_crc_errors;
  logic [RCW-1:0] restart_cnt, next_restart_cnt;
  logic           buf_we;
  logic [7:0]     frame_buf [FRAME_DEPTH];

  // ----------------------------------------------------------------
  // Frame field decode
  // ----------------------------------------------------------------
  logic [7:0]  fc;
  logic [15:0] word1;
  logic [15:0] word2;
  logic [7:0]  byte_count;
  logic        crc_ok;
  logic        write_ok;
  logic        diag_ok;
  logic        is_restart;
  logic [7:0]  pay_hi;
  logic [7:0]  pay_lo;

  // Fields sit at fixed places; word1 is start index or subfunction
  assign fc         = frame_buf[POS_FC];
  assign word1      = {frame_buf[POS_WORD1_HI], frame_buf[POS_WORD1_LO]};
  assign word2      = {frame_buf[POS_WORD2_HI], frame_buf[POS_WORD2_LO]};
  assign byte_count = frame_buf[POS_BYTE_COUNT];
  assign crc_ok     = (rx_crc == CRC_GOOD) && !overflow
                      && (rx_cnt >= MIN_FRAME_LEN);            // see [R14]
  // Count 1..127 only, or the write loop would never reach its end
  assign write_ok   = (fc == FC_WRITE_MULTI) && (word2 != '0) && !word2[15]
                      && ({8'h00, byte_count} == {word2[14:0], 1'b0})
                      && (rx_cnt == WRITE_OVERHEAD + {1'b0, byte_count});
  assign diag_ok    = (fc == FC_DIAG) && (rx_cnt == DIAG_FRAME_LEN)
                      && (word1 == loopback_subfunction
                       || word1 == port_restart_subfunction
                       || word1 == SUB_DIAG_WORD
                       || word1 == SUB_CLEAR
                       || word1 == SUB_CRC_COUNT);             // see [R5]
  assign is_restart = (fc == FC_DIAG) && (word1 == port_restart_subfunction);
  // Two payload bytes per register, high byte first
  assign pay_hi = frame_buf[8'(POS_PAYLOAD + {wr_idx, 1'b0})]; // see [R4]
  assign pay_lo = frame_buf[8'(POS_PAYLOAD + {wr_idx, 1'b0} + 8'h01)];

  // Reply bytes: first four come from the request, then the data word, then checksum
  function automatic logic [7:0] reply_byte(input logic [2:0]  idx,
                                            input logic [15:0] crc);
    logic [15:0] data;
    data = word2;                                             // see [R6]
    if (fc == FC_DIAG && word1 == SUB_DIAG_WORD) begin
      data = diagnostic_status_word;                          // see [R9]
    end else if (fc == FC_DIAG && word1 == SUB_CRC_COUNT) begin
      data = crc_error_count;                                 // see [R12]
    end
    case (idx)
      3'h4:      reply_byte = data[15:8];
      3'h5:      reply_byte = data[7:0];
      TX_CRC_LO: reply_byte = crc[7:0];
      TX_CRC_HI: reply_byte = crc[15:8];
      default:   reply_byte = frame_buf[{5'h00, idx}];        // see [R3]
    endcase
  endfunction : reply_byte

  assign tx_valid     = (state == ST_REPLY);
  assign port_restart = (state == ST_RESTART);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Status bits are sticky; a set in a clearing cycle survives
  always_comb begin
    logic [15:0] crc_n;
    crc_n            = crc_step(tx_crc, tx_data);
    next_state       = state;
    next_rx_cnt      = rx_cnt;
    next_rx_crc      = rx_crc;
    next_overflow    = overflow;
    next_wr_idx      = wr_idx;
    next_tx_idx      = tx_idx;
    next_tx_crc      = tx_crc;
    next_tx_data     = tx_data;
    next_reg_write   = '0;
    next_status      = diagnostic_status_word | diag_event;
    next_crc_errors  = crc_error_count;
    next_restart_cnt = restart_cnt;
    buf_we           = 1'b0;
    case (state)
      ST_RECV: begin
        if (rx.valid && rx_cnt == FRAME_FULL) begin
          next_overflow = 1'b1;
        end else if (rx.valid) begin
          buf_we      = 1'b1;                                 // see [R1]
          next_rx_cnt = rx_cnt + 9'h001;
          next_rx_crc = crc_step(rx_crc, rx.data);
        end
        if (rx_frame_end) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_rx_cnt   = '0;
        next_rx_crc   = CRC_INIT;
        next_overflow = 1'b0;
        next_wr_idx   = '0;
        next_tx_idx   = '0;
        next_tx_crc   = CRC_INIT;
        next_tx_data  = reply_byte(3'h0, CRC_INIT);
        next_state    = ST_RECV;
        if (!crc_ok) begin
          if (rx_cnt != 9'h000) begin
            next_crc_errors = crc_error_count + 16'h0001;     // see [R13]
          end
        end else if (frame_buf[POS_ADDR] != slave_addr) begin
          next_state = ST_RECV;
        end else if (write_ok) begin
          next_state = ST_WRITE;
        end else if (diag_ok) begin
          next_state = ST_REPLY;
          if (word1 == SUB_CLEAR) begin
            next_status     = diag_event;                     // see [R11]
            next_crc_errors = '0;                             // see [R10]
          end
        end
      end
      ST_WRITE: begin
        next_reg_write.en    = 1'b1;
        next_reg_write.index = word1 + {8'h00, wr_idx};       // see [R2]
        next_reg_write.data  = {pay_hi, pay_lo};
        next_wr_idx          = wr_idx + 8'h01;
        if ({8'h00, wr_idx} == word2 - 16'h0001) begin
          next_state = ST_REPLY;
        end
      end
      ST_REPLY: begin
        if (tx_ready) begin
          if (tx_idx < TX_CRC_LO) begin
            next_tx_crc = crc_n;
          end
          next_tx_idx  = tx_idx + 3'h1;
          next_tx_data = reply_byte(tx_idx + 3'h1, next_tx_crc);
          if (tx_idx == TX_CRC_HI) begin
            next_state = ST_RECV;
            if (is_restart) begin
              // Counters drop only once the echo is out
              next_state       = ST_RESTART;              // see [R7]
              next_restart_cnt = '0;
              next_crc_errors  = '0;
            end
          end
        end
      end
      ST_RESTART: begin
        // Port held quiet; bytes arriving now are dropped
        next_restart_cnt = restart_cnt + RCW'(1);
        if (restart_cnt == RESTART_LAST) begin
          next_state = ST_RECV;                               // see [R8]
        end
      end
      default: begin
        next_state = ST_RECV;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state                  <= ST_RECV;
      rx_cnt                 <= '0;
      rx_crc                 <= CRC_INIT;
      overflow               <= 1'b0;
      wr_idx                 <= '0;
      tx_idx                 <= '0;
      tx_crc                 <= CRC_INIT;
      tx_data                <= '0;
      reg_write              <= '0;
      diagnostic_status_word <= '0;
      crc_error_count        <= '0;
      restart_cnt            <= '0;
    end else begin
      state                  <= next_state;
      rx_cnt                 <= next_rx_cnt;
      rx_crc                 <= next_rx_crc;
      overflow               <= next_overflow;
      wr_idx                 <= next_wr_idx;
      tx_idx                 <= next_tx_idx;
      tx_crc                 <= next_tx_crc;
      tx_data                <= next_tx_data;
      reg_write              <= next_reg_write;
      diagnostic_status_word <= next_status;
      crc_error_count        <= next_crc_errors;
      restart_cnt            <= next_restart_cnt;
    end
  end
  // Frame store; no reset needed, contents qualified by rx_cnt
  always_ff @(posedge clk) begin
    if (buf_we) begin
      frame_buf[rx_cnt[7:0]] <= rx.data;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_bad_frame;
    state == ST_EXEC && !crc_ok && rx_cnt != 9'h000;
  endsequence
  sequence s_reply_last;
    state == ST_REPLY && tx_ready && tx_idx == TX_CRC_HI;
  endsequence
  property p_bad_counts;
    @(posedge clk) disable iff (sys_rst)
      s_bad_frame |=> crc_error_count == $past(crc_error_count) + 16'h0001;
  endproperty
  a_bad_counts: assert property (p_bad_counts)  // see [R13]
    else $error("checksum error not counted");

  property p_bad_silent;
    @(posedge clk) disable iff (sys_rst)
      s_bad_frame |=> state == ST_RECV ##1 !reg_write.en && !tx_valid;
  endproperty
  a_bad_silent: assert property (p_bad_silent)  // see [R14]
    else $error("bad frame was acted on");

  property p_first_index;
    @(posedge clk) disable iff (sys_rst)
      $rose(state == ST_WRITE) |=> reg_write.en && reg_write.index == word1;
  endproperty
  a_first_index: assert property (p_first_index)  // see [R2]
    else $error("first write not at start index");

  property p_ascending;
    @(posedge clk) disable iff (sys_rst)
      reg_write.en && $past(reg_write.en)
        |-> reg_write.index == $past(reg_write.index) + 16'h0001;
  endproperty
  a_ascending: assert property (p_ascending)  // see [R4]
    else $error("write indices not ascending");

  property p_reply_addr;
    @(posedge clk) disable iff (sys_rst)
      tx_valid && tx_idx == 3'h0 |-> tx_data == frame_buf[POS_ADDR];
  endproperty
  a_reply_addr: assert property (p_reply_addr)  // see [R3]
    else $error("reply does not start with slave address");

  property p_diag_word;
    @(posedge clk) disable iff (sys_rst)
      $past(tx_idx) == 3'h3 && tx_idx == 3'h4 && tx_valid && fc == FC_DIAG
        && word1 == SUB_DIAG_WORD
        |-> tx_data == $past(diagnostic_status_word[15:8]);
  endproperty
  a_diag_word: assert property (p_diag_word)  // see [R9]
    else $error("status word high byte wrong");

  property p_restart_after_reply;
    @(posedge clk) disable iff (sys_rst)
      $rose(port_restart) |-> $past(state) == ST_REPLY
                              && crc_error_count == 16'h0000;
  endproperty
  a_restart_after_reply: assert property (p_restart_after_reply)  // see [R7]
    else $error("restart began before reply finished");

  property p_restart_bounded;
    @(posedge clk) disable iff (sys_rst)
      port_restart |-> restart_cnt <= RESTART_LAST;
  endproperty
  a_restart_bounded: assert property (p_restart_bounded)  // see [R8]
    else $error("restart ran past its limit");

  property p_clear;
    @(posedge clk) disable iff (sys_rst)
      state == ST_EXEC && crc_ok && diag_ok && word1 == SUB_CLEAR
        && frame_buf[POS_ADDR] == slave_addr
        |=> crc_error_count == 16'h0000
            && diagnostic_status_word == $past(diag_event);
  endproperty
  a_clear: assert property (p_clear)  // see [R10]
    else $error("clear did not zero counters");

  property p_restart_echo;
    @(posedge clk) disable iff (sys_rst)
      s_reply_last and is_restart |=> port_restart [*2];
  endproperty
  a_restart_echo: assert property (p_restart_echo)  // see [R7]
    else $error("restart did not follow echo");
endmodule : modbus_write_multi_and_diagnostics

// *** rtl/modbus_diag_pkg.sv ***
// Constants, types and checksum helper for the frame interpreter
package modbus_diag_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_MHZ    = 100;
  localparam int RESTART_TIME_MS = 1000;
  localparam int RESTART_CYCLES  = RESTART_TIME_MS * 1000 * CLK_FREQ_MHZ;
  // ----------------------------------------------------------------
  // Function and subfunction codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  FC_WRITE_MULTI           = 8'h10;
  localparam logic [7:0]  FC_DIAG                  = 8'h08;
  localparam logic [15:0] loopback_subfunction     = 16'h0000;
  localparam logic [15:0] port_restart_subfunction = 16'h0001;
  localparam logic [15:0] SUB_DIAG_WORD            = 16'h0002;
  localparam logic [15:0] SUB_CLEAR                = 16'h000A;
  localparam logic [15:0] SUB_CRC_COUNT            = 16'h000C;
  localparam logic [15:0] DIAG_STATUS_INDEX        = 16'h02BC;
  // ----------------------------------------------------------------
  // Frame layout (byte positions and lengths)
  // ----------------------------------------------------------------
  localparam logic [7:0] POS_ADDR       = 8'h00;
  localparam logic [7:0] POS_FC         = 8'h01;
  localparam logic [7:0] POS_WORD1_HI   = 8'h02;
  localparam logic [7:0] POS_WORD1_LO   = 8'h03;
  localparam logic [7:0] POS_WORD2_HI   = 8'h04;
  localparam logic [7:0] POS_WORD2_LO   = 8'h05;
  localparam logic [7:0] POS_BYTE_COUNT = 8'h06;
  localparam logic [7:0] POS_PAYLOAD    = 8'h07;
  localparam logic [8:0] DIAG_FRAME_LEN = 9'h008;
  localparam logic [8:0] WRITE_OVERHEAD = 9'h009;
  localparam logic [8:0] MIN_FRAME_LEN  = 9'h004;
  localparam logic [2:0] TX_CRC_LO      = 3'h6;
  localparam logic [2:0] TX_CRC_HI      = 3'h7;
  // ----------------------------------------------------------------
  // Checksum
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_RECV    = 5'h01,
    ST_EXEC    = 5'h02,
    ST_WRITE   = 5'h04,
    ST_REPLY   = 5'h08,
    ST_RESTART = 5'h10
  } state_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rx_byte_t;
  typedef struct packed {
    logic        en;
    logic [15:0] index;
    logic [15:0] data;
  } reg_write_t;
  typedef struct packed {
    logic [7:0] diag_status_first;
    logic [7:0] diag_status_second;
  } diag_status_t;
  // One byte through the reflected checksum, LSB first
  function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                           input logic [7:0]  data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_step
endpackage : modbus_diag_pkg

// *** testbench/modbus_master_model.sv ***
// Bus master model: sends request frames and collects reply bytes
`timescale 1ns/1ns
module modbus_master_model
  import modbus_diag_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       hold_off,
  output rx_byte_t        rx,
  output logic            rx_frame_end,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  typedef logic [7:0] byte_q_t[$];
  byte_q_t reply;

  initial begin
    rx = '0;
    rx_frame_end = 1'b0;
    tx_ready = 1'b0;
  end

  // ----------------------------------------------------------------
  // Checksum of the bench's own making
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc16(input byte_q_t q);
    logic [15:0] c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc16

  // Whole frame, checksum low byte first; corrupt flips one bit
  task automatic send(input byte_q_t q, input logic corrupt);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, corrupt};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      @(posedge clk);
      rx <= '{valid: 1'b1, data: q[i]};
    end
    @(posedge clk);
    // Idle line shows the inverse, not a stale byte
    rx <= '{valid: 1'b0, data: ~q[q.size()-1]};
    rx_frame_end <= 1'b1;
    @(posedge clk);
    rx_frame_end <= 1'b0;
  endtask : send

  // Reply sink, stalls when the bench asks for it
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) reply.push_back(tx_data);
    tx_ready <= ~hold_off;
  end
endmodule : modbus_master_model

// *** testbench/test_modbus_write_multi_and_diagnostics.sv ***
// Self-checking bench for the frame interpreter
`timescale 1ns/1ns
module test_modbus_write_multi_and_diagnostics
  import modbus_diag_pkg::*;
;
  typedef logic [7:0] bq_t[$];
  logic         clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         hold_off = 1'b0;
  logic         slow = 1'b0;
  logic [15:0]  diag_event = 16'h0000;
  logic [31:0]  seed = 32'h4762452C;
  logic [31:0]  rs = 32'h4762452C;
  rx_byte_t     rx;
  logic         rx_frame_end;
  logic         tx_ready;
  logic         tx_valid;
  logic         port_restart;
  logic [7:0]   tx_data;
  reg_write_t   reg_write;
  diag_status_t diagnostic_status_word;
  logic [15:0]  crc_error_count;
  logic [31:0]  wr_q[$];
  int           bad_count = 0;
  int           checked = 0;
  int           restart_cycles = 0;
  int           crc_err = 0;
  logic [15:0]  status_m = 16'h0000;
  bq_t          pay;
  int           n;

  always #5 clk = ~clk;

  modbus_write_multi_and_diagnostics #(
    .FRAME_DEPTH      (256),
    .RESTART_CYCLES_P (20)
  ) modbus_write_multi_and_diagnostics_inst (
    .clk(clk), .sys_rst(sys_rst), .slave_addr(8'h4D), .rx(rx),
    .rx_frame_end(rx_frame_end), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .reg_write(reg_write), .diag_event(diag_event),
    .diagnostic_status_word(diagnostic_status_word),
    .crc_error_count(crc_error_count), .port_restart(port_restart)
  );

  modbus_master_model modbus_master_model_inst (
    .clk(clk), .hold_off(hold_off), .rx(rx), .rx_frame_end(rx_frame_end),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready)
  );

  // ----------------------------------------------------------------
  // Helpers and monitors
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  // Random stalls on the reply side when slow is set
  always @(posedge clk) begin
    rs <= xs(rs);
    hold_off <= slow & rs[0];
  end

  always @(posedge clk) begin
    if (reg_write.en === 1'b1)
      wr_q.push_back({reg_write.index, reg_write.data});
    if (port_restart === 1'b1) begin
      restart_cycles++;
      if (tx_valid !== 1'b0) begin
        $display("wrong value tx_valid expected 0 seen %b", tx_valid);
        bad_count++;
      end
    end
  end

  task automatic summarize();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : chk

  function automatic bq_t with_crc(bq_t q);
    logic [15:0] c;
    c = modbus_master_model_inst.crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    return q;
  endfunction : with_crc

  // Send, wait bounded for the reply, then compare byte by byte
  task automatic run(bq_t req, logic bad, int n_rep, bq_t exp);
    int k;
    k = 0;
    modbus_master_model_inst.reply.delete();
    modbus_master_model_inst.send(req, bad);
    while (modbus_master_model_inst.reply.size() < n_rep && k < 400) begin
      @(posedge clk);
      k++;
    end
    if (modbus_master_model_inst.reply.size() < n_rep) begin
      $display("wrong value reply wait expected done seen timeout");
      bad_count++;
    end
    // Long enough for stray bytes and the whole restart hold
    repeat (40) @(posedge clk);
    chk("reply length", n_rep, modbus_master_model_inst.reply.size());
    for (int i = 0; i < n_rep; i++)
      chk("reply byte", exp[i], modbus_master_model_inst.reply[i]);
  endtask : run

  task automatic diag(logic [15:0] sub, logic [15:0] dat, logic [15:0] ret);
    bq_t req;
    req = {8'h4D, FC_DIAG, sub[15:8], sub[7:0], dat[15:8], dat[7:0]};
    run(req, 1'b0, 8, with_crc({req[0:3], ret[15:8], ret[7:0]}));
  endtask : diag

  task automatic wr(logic [15:0] start, int cnt, bq_t p, logic bad);
    bq_t req;
    req = {8'h4D, FC_WRITE_MULTI, start[15:8], start[7:0], 8'h00,
           8'(cnt), 8'(2 * cnt), p};
    wr_q.delete();
    run(req, bad, bad ? 0 : 8, with_crc(req[0:5]));
    chk("write count", bad ? 0 : cnt, wr_q.size());
    for (int i = 0; i < wr_q.size(); i++)
      chk("write", {start + 16'(i), p[2*i], p[2*i+1]}, wr_q[i]);
  endtask : wr

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("status", 16'h0000, diagnostic_status_word);
    chk("crc count", 16'h0000, crc_error_count);
    chk("port restart", 1'b0, port_restart);
    diag(loopback_subfunction, 16'h00FD, 16'h00FD);
    // Restart request for another node must stay unanswered
    pay = {8'h4E, FC_DIAG, 8'h00, 8'h01, 8'h00, 8'h00};
    run(pay, 1'b0, 0, pay);
    chk("restart hold", 0, restart_cycles);
    chk("crc count", 16'h0000, crc_error_count);
    wr(16'h012E, 4, {8'h43, 8'h55, 8'h53, 8'h54, 8'h4F, 8'h4D, 8'h45,
                     8'h52}, 1'b0);
    slow <= 1'b1;
    for (int t = 0; t < 3; t++) begin
      seed = xs(seed);
      n = 1 + int'(seed[1:0]);
      pay.delete();
      for (int i = 0; i < 2 * n; i++) begin
        seed = xs(seed);
        pay.push_back(seed[7:0]);
      end
      wr(t == 0 ? 16'h0000 : seed[31:16], n, pay, t == 2);
      if (t == 2) crc_err++;
      diag(loopback_subfunction, seed[15:0], seed[15:0]);
    end
    chk("crc count", crc_err, crc_error_count);
    diag(SUB_CRC_COUNT, 16'h0000, 16'(crc_err));
    // Status bits are sticky, so a one-cycle event must remain
    seed = xs(seed);
    diag_event <= seed[15:0];
    @(posedge clk);
    diag_event <= 16'h0000;
    status_m = seed[15:0];
    diag(SUB_DIAG_WORD, 16'h0000, status_m);
    // Held event during clear is expected to come straight back
    diag_event <= 16'h0081;
    diag(SUB_CLEAR, 16'h0000, 16'h0000);
    chk("status", 16'h0081, diagnostic_status_word);
    diag_event <= 16'h0000;
    crc_err = 0;
    diag(SUB_CRC_COUNT, 16'h0000, 16'h0000);
    wr(16'h0005, 1, {8'h12, 8'h34}, 1'b1);
    crc_err++;
    // A non-zero count proves that the restart does the zeroing
    chk("crc count", crc_err, crc_error_count);
    restart_cycles = 0;
    diag(port_restart_subfunction, 16'h0000, 16'h0000);
    crc_err = 0;
    chk("restart hold", 20, restart_cycles);
    diag(SUB_CRC_COUNT, 16'h0000, 16'(crc_err));
    summarize();
  end
endmodule : test_modbus_write_multi_and_diagnostics
